// ==== src/fspg_pkg.sv ====
// Package with the sector map, modes and timing constants of the flash sector guard.
package fspg_pkg;
	localparam int ADDR_W = 16;
	localparam logic [15:0] SECTOR0_BASE = 16'hF000;
	localparam logic [15:0] SECTOR0_TOP = 16'hFFFF;
	localparam logic [15:0] SECTOR1_BASE = 16'hE000;
	localparam logic [16:0] SIZE_4K = 17'h01000;
	localparam logic [16:0] SIZE_8K = 17'h02000;
	localparam logic [16:0] SIZE_DEFAULT = 17'h10000;
	localparam logic [7:0] KEY1 = 8'h56;
	localparam logic [7:0] KEY2 = 8'hAE;
	localparam int OP_TIME_US = 10;
	localparam int CLK_MHZ = 20;
	localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
	localparam logic [7:0] OP_CNT = 8'(OP_CYCLES - 1);
	typedef enum logic [1:0]
	{
		MODE_TOOL = 2'b00,
		MODE_ICP = 2'b01,
		MODE_IAP = 2'b10
	} fspg_mode_e;
	typedef enum logic [1:0]
	{
		CMD_PROG = 2'b00,
		CMD_SECT_ERASE = 2'b01,
		CMD_BULK_ERASE = 2'b10,
		CMD_OPT_PROG = 2'b11
	} fspg_cmd_e;
	typedef enum logic [2:0]
	{
		ST_LOCKED = 3'b000,
		ST_KEY1 = 3'b001,
		ST_ARMED = 3'b010,
		ST_BUSY = 3'b011,
		ST_DONE = 3'b100
	} fspg_state_e;
endpackage

// ==== src/fspg_sector_if.sv ====
// Interface carrying an address into the sector decoder and the decoded sector back.
`timescale 1ns/1ns
interface fspg_sector_if;
	logic [15:0] addr;
	logic [16:0] flash_size;
	logic [1:0] sector;
	logic valid;
	modport dec (input addr, input flash_size, output sector, output valid);
	modport user (output addr, output flash_size, input sector, input valid);
endinterface

// ==== src/fspg_sector_dec.sv ====
// Sector decoder: maps an address to its sector for the configured array size.
`timescale 1ns/1ns
module fspg_sector_dec
(
	fspg_sector_if.dec s // Address in, sector out.
);
	logic [16:0] low_base;
	always_comb
	begin
		// The largest array fills the whole address space, so its size is also the space's end.
		low_base = fspg_pkg::SIZE_DEFAULT - s.flash_size;
		s.sector = 2'h0;
		s.valid = 1'b0;
		if (s.addr >= fspg_pkg::SECTOR0_BASE)
		begin
			s.sector = 2'h0;
			s.valid = 1'b1;
		end
		else if (s.addr >= fspg_pkg::SECTOR1_BASE)
		begin
			s.sector = 2'h1;
			s.valid = (s.flash_size > fspg_pkg::SIZE_4K);
		end
		else
		begin
			s.sector = 2'h2;
			s.valid = (s.flash_size > fspg_pkg::SIZE_8K) && ({1'b0, s.addr} >= low_base);
		end
	end
endmodule

// ==== src/fspg_guard.sv ====
// Flash sector program guard: key unlock, mode permission check and operation sequencing.
// Summary of operation
// - Erase either the whole array or one selected sector.
// - Program one byte per operation, needing the external programming supply.
// - Erasing or programming one sector leaves other sectors untouched.
// - In programming tool mode all sectors and option bytes are writable.
// - In in-circuit mode all sectors and option bytes are writable on board.
// - In in-application mode all sectors except sector 0 are writable.
// - A key sequence must precede any program or erase operation.
// - Up to three user sectors, each erasable independently.
// - The two top sectors are fixed at 4 Kbytes.
// - Sector 0 spans F000h to FFFFh and holds the vectors.
// - 4K has sector 0, 8K sectors 0 and 1, larger all three.
`timescale 1ns/1ns
module fspg_guard
(
	input wire logic SYS_CLK, // 20 MHz clock.
	input wire logic RSTN, // Asynchronous reset, active low.
	input wire logic [1:0] MODE, // Programming mode, fspg_mode_e coding.
	input wire logic [16:0] FLASH_SIZE, // Array size in bytes.
	input wire logic VPP_OK, // External programming supply present, from a pin.
	input wire logic KEY_WR, // Key byte write strobe.
	input wire logic [7:0] KEY_DATA, // Key byte.
	input wire logic REQ, // Operation request strobe.
	input wire logic [1:0] CMD, // Operation, fspg_cmd_e coding.
	input wire logic [15:0] ADDR, // Target address, or a sector address for erase.
	input wire logic [7:0] WDATA, // Byte to program.
	output logic ACK, // Request accepted, one cycle.
	output logic REFUSED, // Request refused, one cycle.
	output logic BUSY, // Operation in progress.
	output logic DONE, // Operation finished, one cycle.
	output logic ARR_PROG, // Array byte program strobe.
	output logic ARR_SECT_ERASE, // Array sector erase strobe.
	output logic ARR_BULK_ERASE, // Array bulk erase strobe.
	output logic ARR_OPT_PROG, // Option byte program strobe.
	output logic [15:0] ARR_ADDR, // Array address.
	output logic [1:0] ARR_SECTOR, // Sector selected for erase.
	output logic [7:0] ARR_WDATA // Array program data.
);
	// Every register of the guard lives in this one struct so reset and update stay in step.
	typedef struct packed
	{
		fspg_pkg::fspg_state_e st;
		logic [7:0] cnt;
		logic vpp_m;
		logic vpp_s;
		logic ack;
		logic refused;
		logic done;
		logic prog;
		logic serase;
		logic berase;
		logic oprog;
		logic [15:0] addr;
		logic [1:0] sector;
		logic [7:0] wdata;
	} fspg_state_s;
	fspg_state_s r_q;
	fspg_state_s r_d;
	logic req_ok;

	// The decoder looks at the live address, so its answer is ready in the request cycle.
	fspg_sector_if sif ();
	assign sif.addr = ADDR;
	assign sif.flash_size = FLASH_SIZE;
	fspg_sector_dec u_dec
	(
		.s(sif)
	);

	// Program and sector erase act on one sector, so only they depend on the address decode.
	function automatic logic is_sector_cmd(input logic [1:0] cmd);
		return (cmd == fspg_pkg::CMD_PROG) || (cmd == fspg_pkg::CMD_SECT_ERASE);
	endfunction

	// Whole-array and option operations would reach the vector sector, so they count as sector 0.
	function automatic logic touches_sector0(input logic [1:0] cmd, input logic [1:0] sector);
		return !is_sector_cmd(cmd) || (sector == 2'h0);
	endfunction

	// Sector 0 and option bytes are only writable from the tool or in-circuit modes.
	function automatic logic allowed(input logic [1:0] mode, input logic [1:0] cmd,
		input logic [1:0] sector, input logic valid);
		logic ok;
		ok = 1'b0;
		case (mode)
			fspg_pkg::MODE_TOOL:
				ok = 1'b1;
			fspg_pkg::MODE_ICP:
				ok = 1'b1;
			fspg_pkg::MODE_IAP:
				ok = !touches_sector0(cmd, sector);
			default:
				ok = 1'b0;
		endcase
		if (is_sector_cmd(cmd))
			ok = ok && valid;
		return ok;
	endfunction

	// Only the second stage of the supply synchroniser is read; the first may be metastable.
	assign req_ok = r_q.vpp_s && allowed(MODE, CMD, sif.sector, sif.valid);

	always_comb
	begin
		r_d = r_q;
		r_d.vpp_m = VPP_OK;
		r_d.vpp_s = r_q.vpp_m;
		r_d.ack = 1'b0;
		r_d.refused = 1'b0;
		r_d.done = 1'b0;
		r_d.prog = 1'b0;
		r_d.serase = 1'b0;
		r_d.berase = 1'b0;
		r_d.oprog = 1'b0;

		case (r_q.st)
			fspg_pkg::ST_LOCKED:
			begin
				// A request before the keys is refused; this is what stops stray writes.
				if (REQ)
					r_d.refused = 1'b1;
				else if (KEY_WR && KEY_DATA == fspg_pkg::KEY1)
					r_d.st = fspg_pkg::ST_KEY1;
			end
			fspg_pkg::ST_KEY1:
			begin
				if (REQ)
				begin
					r_d.refused = 1'b1;
					r_d.st = fspg_pkg::ST_LOCKED;
				end
				else if (KEY_WR)
				begin
					if (KEY_DATA == fspg_pkg::KEY2)
						r_d.st = fspg_pkg::ST_ARMED;
					else
						r_d.st = fspg_pkg::ST_LOCKED;
				end
			end
			fspg_pkg::ST_ARMED:
			begin
				// A key write while armed is taken as a stray access and relocks.
				if (KEY_WR)
					r_d.st = fspg_pkg::ST_LOCKED;
				else if (REQ)
				begin
					// The guard relocks after every request so a runaway loop gets one shot.
					r_d.st = fspg_pkg::ST_LOCKED;
					if (req_ok)
					begin
						r_d.ack = 1'b1;
						r_d.st = fspg_pkg::ST_BUSY;
						r_d.cnt = fspg_pkg::OP_CNT;
						r_d.addr = ADDR;
						r_d.sector = sif.sector;
						r_d.wdata = WDATA;
						case (CMD)
							fspg_pkg::CMD_PROG:
								r_d.prog = 1'b1;
							fspg_pkg::CMD_SECT_ERASE:
								r_d.serase = 1'b1;
							fspg_pkg::CMD_BULK_ERASE:
								r_d.berase = 1'b1;
							fspg_pkg::CMD_OPT_PROG:
								r_d.oprog = 1'b1;
							default:
								r_d.prog = 1'b0;
						endcase
					end
					else
						// A refused request raises no strobe, so the array is left untouched.
						r_d.refused = 1'b1;
				end
			end
			fspg_pkg::ST_BUSY:
			begin
				// The counter stands in for the array's own program or erase time.
				if (REQ)
					r_d.refused = 1'b1;
				if (r_q.cnt == 8'h00)
					r_d.st = fspg_pkg::ST_DONE;
				else
					r_d.cnt = r_q.cnt - 8'h01;
			end
			fspg_pkg::ST_DONE:
			begin
				// One cycle here sets the done pulse, which shows in the first locked cycle, when keys can already be taken again.
				if (REQ)
					r_d.refused = 1'b1;
				r_d.done = 1'b1;
				r_d.st = fspg_pkg::ST_LOCKED;
			end
			default:
				r_d.st = fspg_pkg::ST_LOCKED;
		endcase
	end

	// Reset clears every field, which leaves the guard locked with all strobes low.
	always_ff @(posedge SYS_CLK or negedge RSTN)
	begin
		if (!RSTN)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	// Outputs come straight from the state register, except BUSY, which is decoded from the state field.
	assign ACK = r_q.ack;
	assign REFUSED = r_q.refused;
	assign BUSY = (r_q.st == fspg_pkg::ST_BUSY);
	assign DONE = r_q.done;
	assign ARR_PROG = r_q.prog;
	assign ARR_SECT_ERASE = r_q.serase;
	assign ARR_BULK_ERASE = r_q.berase;
	assign ARR_OPT_PROG = r_q.oprog;
	assign ARR_ADDR = r_q.addr;
	assign ARR_SECTOR = r_q.sector;
	assign ARR_WDATA = r_q.wdata;
endmodule

// ==== dv/fspg_chk.sv ====
// Port checker for the flash sector guard.
`timescale 1ns/1ns
module fspg_chk
(
	input wire logic SYS_CLK, // Clock.
	input wire logic RSTN, // Reset.
	input wire logic [1:0] MODE, // Mode.
	input wire logic [16:0] FLASH_SIZE, // Size.
	input wire logic KEY_WR, // Key strobe.
	input wire logic REQ, // Request.
	input wire logic [1:0] CMD, // Command.
	input wire logic [15:0] ADDR, // Address.
	input wire logic ACK, // Accept.
	input wire logic REFUSED, // Refuse.
	input wire logic BUSY, // Busy.
	input wire logic DONE, // Done.
	input wire logic ARR_PROG, // Program.
	input wire logic ARR_SECT_ERASE, // Erase.
	input wire logic [15:0] ARR_ADDR, // Array address.
	input wire logic [1:0] ARR_SECTOR // Sector.
);
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!RSTN);
	property p_iap0; REQ && MODE == 2'h2 && !CMD[1] && ADDR[15:12] == 4'hF |=> !ACK; endproperty
	a_iap0: assert property (p_iap0) else $error("Sector 0 accepted in app mode.");
	property p_iapbulk; REQ && MODE == 2'h2 && CMD[1] |=> !ACK; endproperty
	a_iapbulk: assert property (p_iapbulk) else $error("Bulk or option accepted.");
	property p_prog; ACK |-> ARR_PROG == ($past(CMD) == 2'h0); endproperty
	a_prog: assert property (p_prog) else $error("Program strobe wrong.");
	property p_sec0; ARR_SECT_ERASE && ARR_ADDR[15:12] == 4'hF |-> ARR_SECTOR == 2'h0; endproperty
	a_sec0: assert property (p_sec0) else $error("Top range not sector 0.");
	property p_done; ACK |-> ##[200:203] DONE; endproperty
	a_done: assert property (p_done) else $error("No done after accept.");
	property p_ans; REQ && !KEY_WR |=> ACK != REFUSED; endproperty
	a_ans: assert property (p_ans) else $error("Request not answered once.");
	property p_busyreq; BUSY && REQ |=> !ACK; endproperty
	a_busyreq: assert property (p_busyreq) else $error("Accepted while busy.");
	property p_size; REQ && FLASH_SIZE == 17'h01000 && !CMD[1] && ADDR[15:12] != 4'hF |=> !ACK;
	endproperty
	a_size: assert property (p_size) else $error("Missing sector accepted.");
	c_iap: cover property (ACK && MODE == 2'h2);
	c_ref: cover property (REFUSED && BUSY);
	c_done: cover property (DONE);
endmodule
bind fspg_guard fspg_chk i_chk (.SYS_CLK, .RSTN, .MODE, .FLASH_SIZE, .KEY_WR, .REQ, .CMD, .ADDR,
	.ACK, .REFUSED, .BUSY, .DONE, .ARR_PROG, .ARR_SECT_ERASE, .ARR_ADDR, .ARR_SECTOR);

// ==== dv/fspg_arr_model.sv ====
// Flash array model keeping one byte per sector.
`timescale 1ns/1ns
module fspg_arr_model
(
	input wire logic clk, // Clock.
	input wire logic prog, // Program.
	input wire logic sect_erase, // Sector erase.
	input wire logic bulk_erase, // Bulk erase.
	input wire logic [15:0] addr, // Address.
	input wire logic [1:0] sector, // Erase sector.
	input wire logic [7:0] wdata, // Data.
	output logic [2:0][7:0] mem // Byte per sector.
);
	// The cells have one writer; the port only mirrors them.
	logic [2:0][7:0] cells = '0;
	assign mem = cells;
	always @(posedge clk)
	begin
		if (bulk_erase)
			cells <= '1;
		if (sect_erase)
			cells[sector] <= 8'hFF;
		if (prog)
			cells[addr[15:12] == 4'hF ? 2'h0 : addr[15:12] == 4'hE ? 2'h1 : 2'h2] <= wdata;
	end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench of the flash sector guard.
`timescale 1ns/1ns
module tb_top;
	typedef struct packed {logic [1:0] m; logic [1:0] c; logic [15:0] a; logic [16:0] s; logic ok;}
		fspg_row_s;
	logic clk = 0, rstn = 0, vpp = 1, key_wr = 0, req = 0;
	logic [1:0] mode = 0, cmd = 0, a_sec;
	logic [7:0] key_data = 0, wdata = 0, a_wd;
	logic [15:0] addr = 0, a_addr;
	logic [16:0] size = 17'h10000;
	logic ack, refused, busy, done, a_prog, a_se, a_be, a_op;
	logic [2:0][7:0] mem;
	logic seen_ack, seen_ref;
	logic [3:0] seen_strb;
	int num_errors = 0, n_compared = 0;
	fspg_row_s rows [12] = '{
		'{2'h0, 2'h0, 16'hF000, 17'h10000, 1'h1},
		'{2'h1, 2'h1, 16'hF000, 17'h10000, 1'h1},
		'{2'h2, 2'h0, 16'hE000, 17'h10000, 1'h1},
		'{2'h2, 2'h0, 16'hF010, 17'h10000, 1'h0},
		'{2'h2, 2'h2, 16'h0000, 17'h10000, 1'h0},
		'{2'h0, 2'h3, 16'h0000, 17'h10000, 1'h1},
		'{2'h2, 2'h1, 16'hE000, 17'h01000, 1'h0},
		'{2'h0, 2'h0, 16'h1000, 17'h02000, 1'h0},
		'{2'h0, 2'h2, 16'h0000, 17'h10000, 1'h1},
		'{2'h1, 2'h3, 16'h0000, 17'h10000, 1'h1},
		'{2'h3, 2'h0, 16'hE000, 17'h10000, 1'h0},
		'{2'h0, 2'h0, 16'hC000, 17'h04000, 1'h1}};
	fspg_guard i_dut (.SYS_CLK(clk), .RSTN(rstn), .MODE(mode), .FLASH_SIZE(size), .VPP_OK(vpp),
		.KEY_WR(key_wr), .KEY_DATA(key_data), .REQ(req), .CMD(cmd), .ADDR(addr), .WDATA(wdata),
		.ACK(ack), .REFUSED(refused), .BUSY(busy), .DONE(done), .ARR_PROG(a_prog),
		.ARR_SECT_ERASE(a_se), .ARR_BULK_ERASE(a_be), .ARR_OPT_PROG(a_op), .ARR_ADDR(a_addr),
		.ARR_SECTOR(a_sec), .ARR_WDATA(a_wd));
	fspg_arr_model i_arr (.clk(clk), .prog(a_prog), .sect_erase(a_se), .bulk_erase(a_be),
		.addr(a_addr), .sector(a_sec), .wdata(a_wd), .mem(mem));
	initial forever #25 clk = ~clk;
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// The second key is a parameter so that a wrong key can be sent on purpose.
	task automatic op(input logic [1:0] m, c, input logic [15:0] a, input logic [16:0] s,
		input logic [7:0] k, input bit w);
		int i;
		mode = m;
		size = s;
		key_wr = 1;
		key_data = fspg_pkg::KEY1;
		@(posedge clk) #1;
		key_data = k;
		@(posedge clk) #1;
		key_wr = 0;
		req = 1;
		cmd = c;
		addr = a;
		wdata = a[15:8] ^ 8'h3C;
		@(posedge clk) #1;
		req = 0;
		// Answers stand for one cycle only, so they are caught here.
		seen_ack = ack;
		seen_ref = refused;
		seen_strb = {a_op, a_be, a_se, a_prog};
		i = 0;
		while (w && busy !== 1'b0 && i < 300)
		begin
			@(posedge clk) #1;
			i++;
		end
		if (w)
		begin
			@(posedge clk) #1;
			chk("busy_end", 8'h00, 8'(busy));
		end
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		#1 rstn = 1;
		repeat (3) @(posedge clk) #1;
		foreach (rows[i])
		begin
			op(rows[i].m, rows[i].c, rows[i].a, rows[i].s, fspg_pkg::KEY2, 0);
			chk("ack", 8'(rows[i].ok), 8'(seen_ack));
			chk("refused", 8'(!rows[i].ok), 8'(seen_ref));
			chk("strobes", 8'(rows[i].ok ? 4'h1 << rows[i].c : 4'h0), 8'(seen_strb));
			op(0, 0, 0, 17'h10000, 8'h00, 1);
		end
		op(0, 0, 16'hE000, 17'h10000, fspg_pkg::KEY2, 1);
		chk("done", 8'h01, 8'(done));
		op(0, 0, 16'h2000, 17'h10000, fspg_pkg::KEY2, 1);
		op(0, 0, 16'hF100, 17'h10000, fspg_pkg::KEY2, 1);
		op(2, 1, 16'hF000, 17'h10000, fspg_pkg::KEY2, 1);
		chk("iap_sector0", 8'h01, 8'(seen_ref));
		op(0, 1, 16'hE000, 17'h10000, fspg_pkg::KEY2, 1);
		chk("sector1", 8'hFF, mem[1]);
		chk("sector2", 8'h1C, mem[2]);
		chk("sector0", 8'hCD, mem[0]);
		op(0, 0, 16'hE000, 17'h10000, 8'h00, 1);
		chk("badkey", 8'h00, 8'(seen_ack));
		chk("badkey_done", 8'h00, 8'(done));
		vpp = 0;
		op(0, 0, 16'hE000, 17'h10000, fspg_pkg::KEY2, 1);
		chk("novpp", 8'h00, 8'(seen_ack));
		vpp = 1;
		op(1, 0, 16'hE000, 17'h10000, fspg_pkg::KEY2, 0);
		op(1, 0, 16'hE000, 17'h10000, fspg_pkg::KEY2, 1);
		chk("busyreq", 8'h01, 8'(seen_ref));
		// A reset in the middle of an accepted operation must drop it and relock the guard.
		op(0, 0, 16'hE000, 17'h10000, fspg_pkg::KEY2, 0);
		rstn = 0;
		@(posedge clk) #1;
		chk("rst_busy", 8'h00, 8'(busy));
		rstn = 1;
		repeat (2) @(posedge clk) #1;
		chk("rst_idle", 8'h00, 8'({ack, refused, busy, done}));
		req = 1;
		@(posedge clk) #1;
		req = 0;
		chk("rst_locked", 8'h01, 8'(refused));
		give_verdict();
	end
	initial
	begin
		#2000000;
		num_errors++;
		give_verdict();
	end
endmodule
